// ==== odm_pkg.sv ====
// Constants for the output dependency matrix
package odm_pkg;
	localparam int ODM_NUM_OUT = 4;
	localparam int ODM_NUM_DET = 8;
	localparam int ODM_NUM_GPI = 4;
	localparam int ODM_MISC_W = 6;
	localparam logic [7:0] ODM_ADDR_OUT2_DET = 8'h0D;
	localparam logic [7:0] ODM_ADDR_OUT2_MISC = 8'h0E;
	localparam logic [7:0] ODM_ADDR_OUT3_DET = 8'h10;
	localparam logic [7:0] ODM_ADDR_OUT3_MISC = 8'h11;
	localparam logic [7:0] ODM_ADDR_OUT4_DET = 8'h13;
	localparam logic [7:0] ODM_ADDR_OUT4_MISC = 8'h14;
	localparam logic [7:0] ODM_ADDR_OUT5_DET = 8'h16;
	localparam logic [7:0] ODM_ADDR_OUT5_MISC = 8'h17;
	localparam int ODM_MISC_WD_BIT = 0;
	localparam int ODM_MISC_GPI_LSB = 1;
	localparam int ODM_MISC_MR_BIT = 5;
	localparam logic [7:0] ODM_DET_RESET = 8'h00;
	localparam logic [5:0] ODM_MISC_RESET = 6'h00;
	localparam logic [7:0] ODM_RDATA_UNMAPPED = 8'h00;
	localparam logic [4:0] ODM_SYNC_RESET = 5'h1F;
	localparam int ODM_OUT2 = 0;
	localparam int ODM_OUT3 = 1;
	localparam int ODM_OUT4 = 2;
	localparam int ODM_OUT5 = 3;
endpackage

// ==== odm_dep_if.sv ====
// Selection and condition bundle for one programmable output
`timescale 1ns/10ps
`default_nettype none
interface odm_dep_if;
	logic [odm_pkg::ODM_NUM_DET-1:0] det_sel;
	logic [odm_pkg::ODM_MISC_W-1:0] misc_sel;
	logic [odm_pkg::ODM_NUM_DET-1:0] uv_flag;
	logic wd_flag;
	logic [odm_pkg::ODM_NUM_GPI-1:0] gpi_flag;
	logic mr_low;
	logic req;
	modport ctl (
		output det_sel, misc_sel, uv_flag, wd_flag, gpi_flag, mr_low,
		input req
	);
	modport comb (
		input det_sel, misc_sel, uv_flag, wd_flag, gpi_flag, mr_low,
		output req
	);
endinterface
`default_nettype wire

// ==== odm_dep_combiner.sv ====
// OR of the selected assertion conditions of one output
`timescale 1ns/10ps
`default_nettype none
module odm_dep_combiner (
	odm_dep_if.comb dep
);
	logic uv_hit;
	logic misc_hit;
	always_comb begin
		// A cleared bit masks its condition out
		uv_hit = |(dep.det_sel & dep.uv_flag); // RL4 RL8 RL12 RL13
		misc_hit = (dep.misc_sel[odm_pkg::ODM_MISC_WD_BIT] & dep.wd_flag)
			| |(dep.misc_sel[odm_pkg::ODM_MISC_GPI_LSB +: odm_pkg::ODM_NUM_GPI]
			& dep.gpi_flag)
			| (dep.misc_sel[odm_pkg::ODM_MISC_MR_BIT] & dep.mr_low);
		// No selection means never asserted
		dep.req = uv_hit | misc_hit; // RL14
	end
endmodule
`default_nettype wire

// ==== odm_output_dependency_matrix.sv ====
// Dependency select registers and assertion requests, outputs 2 to 5
// What this block does
// RL1 - Output three follows selected detectors 1-8
// RL2 - Output three adds watchdog, logic inputs 1-4
// RL3 - Output three asserts while manual reset low
// RL4 - Output three ignores cleared selections
// RL5 - Output four follows selected detectors 1-8
// RL6 - Output four adds watchdog, logic inputs 1-4
// RL7 - Output four asserts while manual reset low
// RL8 - Output four ignores cleared selections
// RL9 - Output five follows selected detectors 1-8
// RL10 - Output five adds watchdog, logic inputs 1-4
// RL11 - Output five asserts while manual reset low
// RL12 - Output five ignores cleared selections
// RL13 - Output two ignores cleared selections
// RL14 - Request is OR of selections; none, never
`timescale 1ns/10ps
`default_nettype none
module odm_output_dependency_matrix (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr_en,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire logic [7:0] i_voltage_detector_uv,
	input wire logic i_watchdog_expiry,
	input wire logic [3:0] i_logic_input_n,
	input wire logic i_manual_reset_n,
	output logic o_prog_output_two_req,
	output logic o_prog_output_three_req,
	output logic o_prog_output_four_req,
	output logic o_prog_output_five_req
);
	localparam int NO = odm_pkg::ODM_NUM_OUT;
	localparam int MW = odm_pkg::ODM_MISC_W;

	// One write strobe per mapped offset
	logic wr_det2;
	logic wr_misc2;
	logic wr_det3;
	logic wr_misc3;
	logic wr_det4;
	logic wr_misc4;
	logic wr_det5;
	logic wr_misc5;

	// Selection registers, one group per output
	logic [7:0] det2_q;
	logic [7:0] det2_d;
	logic [MW-1:0] misc2_q;
	logic [MW-1:0] misc2_d;

	logic [7:0] det3_q;
	logic [7:0] det3_d;
	logic [MW-1:0] misc3_q;
	logic [MW-1:0] misc3_d;

	logic [7:0] det4_q;
	logic [7:0] det4_d;
	logic [MW-1:0] misc4_q;
	logic [MW-1:0] misc4_d;

	logic [7:0] det5_q;
	logic [7:0] det5_d;
	logic [MW-1:0] misc5_q;
	logic [MW-1:0] misc5_d;

	// Read data register
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	// Pins cross in through two flops; bit 4 is manual reset
	logic [4:0] sync1_q;
	logic [4:0] sync1_d;
	logic [4:0] sync2_q;
	logic [4:0] sync2_d;

	// Assertion requests before and after the output flop
	logic [NO-1:0] req_q;
	logic [NO-1:0] req_d;
	logic [NO-1:0] req_raw;
	// Asserted-level pin conditions shared by every output
	logic [3:0] logic_input_low;
	logic manual_reset_low;

	// Holes in the map match no strobe, so those writes are lost
	always_comb begin
		wr_det2 = i_reg_wr_en && i_reg_addr == odm_pkg::ODM_ADDR_OUT2_DET;
		wr_misc2 = i_reg_wr_en && i_reg_addr == odm_pkg::ODM_ADDR_OUT2_MISC;
		wr_det3 = i_reg_wr_en && i_reg_addr == odm_pkg::ODM_ADDR_OUT3_DET;
		wr_misc3 = i_reg_wr_en && i_reg_addr == odm_pkg::ODM_ADDR_OUT3_MISC;
		wr_det4 = i_reg_wr_en && i_reg_addr == odm_pkg::ODM_ADDR_OUT4_DET;
		wr_misc4 = i_reg_wr_en && i_reg_addr == odm_pkg::ODM_ADDR_OUT4_MISC;
		wr_det5 = i_reg_wr_en && i_reg_addr == odm_pkg::ODM_ADDR_OUT5_DET;
		wr_misc5 = i_reg_wr_en && i_reg_addr == odm_pkg::ODM_ADDR_OUT5_MISC;
	end

	// Output two selects; bits 7:6 of a misc write are dropped
	always_comb begin
		det2_d = det2_q;
		misc2_d = misc2_q;
		if (wr_det2) begin
			det2_d = i_reg_wdata; // RL13
		end
		if (wr_misc2) begin
			misc2_d = i_reg_wdata[MW-1:0]; // RL13
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			det2_q <= odm_pkg::ODM_DET_RESET;
			misc2_q <= odm_pkg::ODM_MISC_RESET;
		end else begin
			det2_q <= det2_d;
			misc2_q <= misc2_d;
		end
	end

	// Output three selects
	always_comb begin
		det3_d = det3_q;
		misc3_d = misc3_q;
		if (wr_det3) begin
			det3_d = i_reg_wdata; // RL1
		end
		if (wr_misc3) begin
			misc3_d = i_reg_wdata[MW-1:0]; // RL2 RL3
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			det3_q <= odm_pkg::ODM_DET_RESET;
			misc3_q <= odm_pkg::ODM_MISC_RESET;
		end else begin
			det3_q <= det3_d;
			misc3_q <= misc3_d;
		end
	end

	// Output four selects
	always_comb begin
		det4_d = det4_q;
		misc4_d = misc4_q;
		if (wr_det4) begin
			det4_d = i_reg_wdata; // RL5
		end
		if (wr_misc4) begin
			misc4_d = i_reg_wdata[MW-1:0]; // RL6 RL7
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			det4_q <= odm_pkg::ODM_DET_RESET;
			misc4_q <= odm_pkg::ODM_MISC_RESET;
		end else begin
			det4_q <= det4_d;
			misc4_q <= misc4_d;
		end
	end

	// Output five selects
	always_comb begin
		det5_d = det5_q;
		misc5_d = misc5_q;
		if (wr_det5) begin
			det5_d = i_reg_wdata; // RL9
		end
		if (wr_misc5) begin
			misc5_d = i_reg_wdata[MW-1:0]; // RL10 RL11
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			det5_q <= odm_pkg::ODM_DET_RESET;
			misc5_q <= odm_pkg::ODM_MISC_RESET;
		end else begin
			det5_q <= det5_d;
			misc5_q <= misc5_d;
		end
	end

	// Readback one cycle after the address; unused bits read zero
	// Reads have no side effects, so any offset may be polled
	always_comb begin
		case (i_reg_addr)
			odm_pkg::ODM_ADDR_OUT2_DET: rdata_d = det2_q;
			odm_pkg::ODM_ADDR_OUT2_MISC: rdata_d = {2'h0, misc2_q};
			odm_pkg::ODM_ADDR_OUT3_DET: rdata_d = det3_q;
			odm_pkg::ODM_ADDR_OUT3_MISC: rdata_d = {2'h0, misc3_q};
			odm_pkg::ODM_ADDR_OUT4_DET: rdata_d = det4_q;
			odm_pkg::ODM_ADDR_OUT4_MISC: rdata_d = {2'h0, misc4_q};
			odm_pkg::ODM_ADDR_OUT5_DET: rdata_d = det5_q;
			odm_pkg::ODM_ADDR_OUT5_MISC: rdata_d = {2'h0, misc5_q};
			default: rdata_d = odm_pkg::ODM_RDATA_UNMAPPED;
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= odm_pkg::ODM_RDATA_UNMAPPED;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Reset value keeps manual reset and logic inputs idle (high)
	always_comb begin
		sync1_d = {i_manual_reset_n, i_logic_input_n};
		sync2_d = sync1_q;
	end

	// Only the second stage is read; the first may be metastable
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sync1_q <= odm_pkg::ODM_SYNC_RESET;
			sync2_q <= odm_pkg::ODM_SYNC_RESET;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// Pins are active low; invert once for all outputs
	assign logic_input_low = ~sync2_q[3:0];
	assign manual_reset_low = ~sync2_q[4];

	// Detector and watchdog flags are on this clock already
	// Output two
	odm_dep_if dep_two ();
	assign dep_two.det_sel = det2_q;
	assign dep_two.misc_sel = misc2_q;
	assign dep_two.uv_flag = i_voltage_detector_uv;
	assign dep_two.wd_flag = i_watchdog_expiry;
	assign dep_two.gpi_flag = logic_input_low;
	assign dep_two.mr_low = manual_reset_low;
	assign req_raw[odm_pkg::ODM_OUT2] = dep_two.req;
	odm_dep_combiner u_comb_two (
		.dep(dep_two)
	);

	// Output three
	odm_dep_if dep_three ();
	assign dep_three.det_sel = det3_q;
	assign dep_three.misc_sel = misc3_q;
	assign dep_three.uv_flag = i_voltage_detector_uv; // RL1
	assign dep_three.wd_flag = i_watchdog_expiry; // RL2
	assign dep_three.gpi_flag = logic_input_low; // RL2
	assign dep_three.mr_low = manual_reset_low; // RL3
	assign req_raw[odm_pkg::ODM_OUT3] = dep_three.req;
	odm_dep_combiner u_comb_three (
		.dep(dep_three)
	);

	// Output four
	odm_dep_if dep_four ();
	assign dep_four.det_sel = det4_q;
	assign dep_four.misc_sel = misc4_q;
	assign dep_four.uv_flag = i_voltage_detector_uv; // RL5
	assign dep_four.wd_flag = i_watchdog_expiry; // RL6
	assign dep_four.gpi_flag = logic_input_low; // RL6
	assign dep_four.mr_low = manual_reset_low; // RL7
	assign req_raw[odm_pkg::ODM_OUT4] = dep_four.req;
	odm_dep_combiner u_comb_four (
		.dep(dep_four)
	);

	// Output five
	odm_dep_if dep_five ();
	assign dep_five.det_sel = det5_q;
	assign dep_five.misc_sel = misc5_q;
	assign dep_five.uv_flag = i_voltage_detector_uv; // RL9
	assign dep_five.wd_flag = i_watchdog_expiry; // RL10
	assign dep_five.gpi_flag = logic_input_low; // RL10
	assign dep_five.mr_low = manual_reset_low; // RL11
	assign req_raw[odm_pkg::ODM_OUT5] = dep_five.req;
	odm_dep_combiner u_comb_five (
		.dep(dep_five)
	);

	always_comb begin
		req_d = req_raw; // RL14
	end

	// Registered so downstream delay logic sees glitch-free requests
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			req_q <= '0;
		end else begin
			req_q <= req_d;
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_prog_output_two_req = req_q[odm_pkg::ODM_OUT2];
	assign o_prog_output_three_req = req_q[odm_pkg::ODM_OUT3];
	assign o_prog_output_four_req = req_q[odm_pkg::ODM_OUT4];
	assign o_prog_output_five_req = req_q[odm_pkg::ODM_OUT5];
endmodule
`default_nettype wire

// ==== odm_dep_sva.sv ====
// Assertion checker for the output dependency matrix
`timescale 1ns/10ps
`default_nettype none
module odm_dep_sva (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr_en,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic [7:0] i_voltage_detector_uv,
	input wire logic i_watchdog_expiry,
	input wire logic [3:0] i_logic_input_n,
	input wire logic i_manual_reset_n,
	input wire logic o_prog_output_two_req,
	input wire logic o_prog_output_three_req,
	input wire logic o_prog_output_four_req,
	input wire logic o_prog_output_five_req
);
	logic [7:0] d[4];
	logic [5:0] m[4];
	logic [4:0] s1, s2;
	logic [3:0] e;
	logic [7:0] rd;
	// Shadow of selects and pin synchronisers, asserted-level flags
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			d <= '{default: 8'h00};
			m <= '{default: 6'h00};
			s1 <= 5'h00;
			s2 <= 5'h00;
		end else begin
			s1 <= {~i_manual_reset_n, ~i_logic_input_n};
			s2 <= s1;
			for (int k = 0; k < 4; k++) begin
				if (i_reg_wr_en && i_reg_addr == 8'h0D + 3 * k) d[k] <= i_reg_wdata;
				if (i_reg_wr_en && i_reg_addr == 8'h0E + 3 * k) m[k] <= i_reg_wdata[5:0];
			end
		end
	end
	always_comb begin
		rd = 8'h00;
		for (int k = 0; k < 4; k++) begin
			if (i_reg_addr == 8'h0D + 3 * k) rd = d[k];
			if (i_reg_addr == 8'h0E + 3 * k) rd = {2'h0, m[k]};
			e[k] = |(d[k] & i_voltage_detector_uv) | (m[k][0] & i_watchdog_expiry)
				| |(m[k][4:1] & s2[3:0]) | (m[k][5] & s2[4]);
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	chk_out2_follow: assert property (
		o_prog_output_two_req == $past(e[0]))
		else $error("output two request wrong");
	chk_out3_follow: assert property (
		o_prog_output_three_req == $past(e[1]))
		else $error("output three request wrong");
	chk_out4_follow: assert property (
		o_prog_output_four_req == $past(e[2]))
		else $error("output four request wrong");
	chk_out5_follow: assert property (
		o_prog_output_five_req == $past(e[3]))
		else $error("output five request wrong");
	chk_none_quiet: assert property (
		d[1] == 8'h00 && m[1] == 6'h00 |=> !o_prog_output_three_req)
		else $error("unselected output asserted");
	chk_mr_assert: assert property (
		s2[4] && m[1][5] |=> o_prog_output_three_req)
		else $error("manual reset not followed");
	chk_wd_assert: assert property (
		i_watchdog_expiry && m[2][0] |=> o_prog_output_four_req)
		else $error("watchdog not followed");
	chk_rdata_map: assert property (
		o_reg_rdata == $past(rd))
		else $error("read data wrong");
	cover property ($rose(o_prog_output_three_req));
	cover property (s2[4] && m[1][5]);
	cover property (i_watchdog_expiry && m[2][0]);
	cover property (i_reg_wr_en && i_reg_addr == 8'h0C);
endmodule
bind odm_output_dependency_matrix odm_dep_sva u_sva (
	.i_clk_sys(i_clk_sys),
	.i_rst(i_rst),
	.i_reg_addr(i_reg_addr),
	.i_reg_wr_en(i_reg_wr_en),
	.i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata),
	.i_voltage_detector_uv(i_voltage_detector_uv),
	.i_watchdog_expiry(i_watchdog_expiry),
	.i_logic_input_n(i_logic_input_n),
	.i_manual_reset_n(i_manual_reset_n),
	.o_prog_output_two_req(o_prog_output_two_req),
	.o_prog_output_three_req(o_prog_output_three_req),
	.o_prog_output_four_req(o_prog_output_four_req),
	.o_prog_output_five_req(o_prog_output_five_req)
);
`default_nettype wire

// ==== odm_rail_model.sv ====
// Rail flags and pin source facing the dependency matrix
`timescale 1ns/10ps
`default_nettype none
module odm_rail_model (
	input wire logic i_clk,
	input wire logic [13:0] i_want,
	output logic [13:0] o_rail
);
	// Falling-edge update keeps the sampling edge free of races
	initial o_rail = 14'h3E00;
	always @(negedge i_clk) o_rail <= i_want;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Random self-checking bench for the dependency matrix
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
$display("ERROR %0t result mismatch", $time); end end
module tb_top;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic i_reg_wr_en = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [7:0] i_reg_wdata = 8'h00;
	logic [13:0] want = 14'h3E00;
	wire logic [13:0] rail;
	wire logic [7:0] rdata;
	wire logic [3:0] req;
	int fail_count = 0;
	int n_checks = 0;
	int dm[4], mm[4], s1, s2, erd;
	logic [3:0] er;
	initial forever #10 i_clk_sys = ~i_clk_sys;
	odm_rail_model u_rail (.i_clk(i_clk_sys), .i_want(want), .o_rail(rail));
	odm_output_dependency_matrix u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_reg_addr(i_reg_addr), .i_reg_wr_en(i_reg_wr_en),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata),
		.i_voltage_detector_uv(rail[7:0]), .i_watchdog_expiry(rail[8]),
		.i_logic_input_n(rail[12:9]), .i_manual_reset_n(rail[13]),
		.o_prog_output_two_req(req[0]), .o_prog_output_three_req(req[1]),
		.o_prog_output_four_req(req[2]), .o_prog_output_five_req(req[3]));
	task automatic step();
		@(posedge i_clk_sys);
		#2;
		erd = 0;
		for (int k = 0; k < 4; k++) begin
			if (i_reg_addr == 13 + 3 * k) erd = dm[k];
			if (i_reg_addr == 14 + 3 * k) erd = mm[k];
			er[k] = (dm[k] & rail[7:0]) != 0 || mm[k][0] && rail[8]
				|| (mm[k] >> 1 & s2 & 15) != 0 || mm[k][5] && s2[4];
			if (i_reg_wr_en && i_reg_addr == 13 + 3 * k) dm[k] = i_reg_wdata;
			if (i_reg_wr_en && i_reg_addr == 14 + 3 * k) mm[k] = i_reg_wdata & 63;
		end
		s2 = s1;
		s1 = {~rail[13], ~rail[12:9]};
		`CHK(req[0], er[0])
		`CHK(req[1], er[1])
		`CHK(req[2], er[2])
		`CHK(req[3], er[3])
		`CHK(rdata, 8'(erd))
		want = {1'($urandom % 4 != 0), 4'($urandom | $urandom),
			1'($urandom % 3 == 0), 8'($urandom & $urandom & $urandom)};
		@(negedge i_clk_sys);
		i_reg_wr_en = $urandom % 3 == 0;
		// Offsets 0C..17 include the unmapped holes
		i_reg_addr = 8'h0C + 8'($urandom % 12);
		i_reg_wdata = $urandom % 4 == 0 ? 8'h00 : 8'($urandom);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h918dd92b));
		repeat (16) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_rst = 1'b0;
		repeat (3000) step();
		finish_test();
	end
endmodule
`default_nettype wire
